// File: design/scf_tx.sv
// character format and transmitter control for one serial channel
// assumes a plain register port on core_clk and a slow transmit clock pin
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`include "scf_params.svh"
module scf_tx
  import scf_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // serial line and modem pins
  input  wire logic       txc_pin,
  output logic            txd,
  output logic            rts_n,
  output logic            dtr_n,
  input  wire logic       sync_i,
  output logic            sync_o,
  output logic            sync_oe,
  // settings shared with the receiver
  output logic            rx_par_en,
  output logic            rx_par_even,
  output logic            rx_crc16,
  output logic      [1:0] rx_rate,
  output logic      [7:0] rx_addr
);
  logic [7:0]  fmt_q, ctl_q, sy1_q, sy2_q, buf_q, rdata_q;
  logic        buf_full_q, latch_q, line_q, txd_q, rts_n_q;
  logic        txc_s1_q, txc_s2_q, txc_s3_q, syn_s1_q, syn_s2_q;
  logic [7:0]  cnt_q;
  logic [15:0] sh_q;
  logic [4:0]  left_q;
  logic [2:0]  ones_q;
  logic        stuff_q, stop_q;
  scf_state_t  st_q;

  scf_crc_if crc_bus();

  scf_crc u_crc (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (crc_bus)
  );

  // decoded settings
  logic       async_m, sdlc_m, bisync_m, pen, peven, tx_en;
  logic [6:0] bitlen;
  logic [8:0] stop_prod;
  logic [7:0] tgt;
  assign async_m  = fmt_q[`SCF_F_STOP] != `SCF_STOP_SYNC;
  assign sdlc_m   = !async_m && fmt_q[`SCF_F_SMODE] == `SCF_M_SDLC;
  assign bisync_m = !async_m && fmt_q[`SCF_F_SMODE] == `SCF_M_BISYNC;
  assign pen      = fmt_q[`SCF_F_PEN] && !sdlc_m;
  assign peven    = fmt_q[`SCF_F_PEVEN];
  assign tx_en    = ctl_q[`SCF_F_TXEN];

  // edges of the transmit clock per bit
  always_comb
  begin
    case (fmt_q[`SCF_F_RATE])
      `SCF_R_X1:  bitlen = `SCF_DIV1;
      `SCF_R_X16: bitlen = `SCF_DIV16;
      `SCF_R_X32: bitlen = `SCF_DIV32;
      default:    bitlen = `SCF_DIV64;
    endcase
  end

  // stop time in half bits: field value plus one; 1.5 at 1x rounds down
  assign stop_prod = 9'(bitlen) * 9'({1'b0, fmt_q[`SCF_F_STOP]} + 3'd1);
  assign tgt = stop_q ? stop_prod[8:1] : {1'b0, bitlen};

  // link clock synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      txc_s1_q <= 1'b1;
      txc_s2_q <= 1'b1;
      txc_s3_q <= 1'b1;
      syn_s1_q <= 1'b1;
      syn_s2_q <= 1'b1;
    end
    else
    begin
      txc_s1_q <= txc_pin;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
      syn_s1_q <= sync_i;
      syn_s2_q <= syn_s1_q;
    end
  end

  // data moves on the falling transmit clock edge
  logic tick, unit_end, stuff_now, adv;
  assign tick      = txc_s3_q && !txc_s2_q;
  assign unit_end  = tick && (cnt_q >= tgt - 8'd1);
  assign stuff_now = stuff_q && ones_q == `SCF_RUN;
  assign adv       = unit_end && !stuff_now && left_q == 5'd0;

  // bit timer
  always_ff @(posedge core_clk)
  begin
    if (rst || unit_end)
      cnt_q <= 8'h00;
    else if (tick)
      cnt_q <= cnt_q + 8'd1;
  end

  // character length, packed form read from the marker zero
  logic [3:0] nb;
  always_comb
  begin
    case (ctl_q[`SCF_F_LEN])
      `SCF_L_PACK:
        casez (buf_q[7:3])
          5'b0????: nb = 4'd5;
          5'b10???: nb = 4'd4;
          5'b110??: nb = 4'd3;
          5'b1110?: nb = 4'd2;
          default:  nb = 4'd1;
        endcase
      `SCF_L_7: nb = 4'd7;
      `SCF_L_6: nb = 4'd6;
      default:  nb = 4'd8;
    endcase
  end

  // character vector: data, parity above it
  logic [8:0]  mask9;
  logic [7:0]  dm;
  logic        par;
  logic [15:0] cvec;
  logic [4:0]  clen;
  assign mask9 = ~(9'h1ff << nb);
  assign dm    = buf_q & mask9[7:0]; // upper bits ignored
  assign par   = (^dm) ^ ~peven;
  assign cvec  = {8'h00, dm} | ({15'h0000, par & pen} << nb);
  assign clen  = {1'b0, nb} + {4'h0, pen};

  // idle pattern per format
  logic [15:0] ipat;
  logic [4:0]  ilen;
  always_comb
  begin
    if (sdlc_m)
      ipat = {`SCF_FLAG, `SCF_FLAG};
    else if (bisync_m)
      ipat = {sy2_q, sy1_q};
    else
      ipat = {sy1_q, sy1_q};
    ilen = bisync_m ? 5'd16 : 5'd8;
  end

  // choice of the next unit at a boundary
  scf_state_t  nx_st;
  logic [15:0] nx_bits;
  logic [4:0]  nx_len;
  logic        nx_stop, nx_stuff, nx_load, nx_latch;
  always_comb
  begin
    nx_st    = st_q;
    nx_bits  = 16'hffff;
    nx_len   = 5'd1;
    nx_stop  = 1'b0;
    nx_load  = 1'b0;
    nx_latch = 1'b0;
    if (st_q == S_DATA && async_m && !stop_q)
      nx_stop = 1'b1;
    else if (!tx_en)
    begin
      // buffered character is kept
      if ((st_q == S_DATA || st_q == S_SMARK) && sdlc_m)
        nx_st = S_SMARK;
      else
        nx_st = S_OFF;
    end
    else if (buf_full_q)
    begin
      nx_st   = S_DATA;
      nx_load = 1'b1;
      nx_bits = async_m ? {cvec[14:0], 1'b0} : cvec;
      nx_len  = async_m ? clen + 5'd1 : clen;
    end
    else if (async_m)
      nx_st = S_MARK;
    else if (st_q == S_DATA && ctl_q[`SCF_F_CRCEN] && !latch_q)
    begin
      nx_st    = S_CRC;
      nx_bits  = crc_bus.crc;
      nx_len   = 5'd16;
      nx_latch = 1'b1;
    end
    else
    begin
      nx_st    = S_IDLE;
      nx_bits  = ipat;
      nx_len   = ilen;
      nx_latch = 1'b1;
    end
    nx_stuff = sdlc_m && (nx_st == S_DATA || nx_st == S_CRC || nx_st == S_SMARK);
  end

  // crc gets each character at load, with the enable seen then
  assign crc_bus.step   = adv && nx_load && ctl_q[`SCF_F_CRCEN];
  assign crc_bus.clr    = adv && nx_st == S_CRC;
  assign crc_bus.poly16 = ctl_q[`SCF_F_POLY];
  assign crc_bus.dat    = dm;
  assign crc_bus.nbits  = nb;

  // outgoing bit; disabled crc phase swaps in idle bits at the same place
  logic [3:0] pos;
  logic       bit_o;
  assign pos   = 4'(5'd16 - left_q);
  assign bit_o = (st_q == S_CRC && !tx_en) ? ipat[pos] : sh_q[0];

  // serialiser with sdlc zero insertion
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q    <= S_OFF;
      line_q  <= 1'b1;
      sh_q    <= 16'hffff;
      left_q  <= 5'd0;
      ones_q  <= 3'h0;
      stuff_q <= 1'b0;
      stop_q  <= 1'b0;
    end
    else if (unit_end)
    begin
      if (stuff_now)
      begin
        line_q <= 1'b0;
        ones_q <= 3'h0;
      end
      else if (left_q != 5'd0)
      begin
        line_q <= bit_o;
        sh_q   <= sh_q >> 1;
        left_q <= left_q - 5'd1;
        ones_q <= (stuff_q && bit_o) ? ones_q + 3'h1 : 3'h0;
      end
      else
      begin
        st_q    <= nx_st;
        line_q  <= nx_bits[0];
        sh_q    <= nx_bits >> 1;
        left_q  <= nx_len - 5'd1;
        stop_q  <= nx_stop;
        stuff_q <= nx_stuff;
        ones_q  <= (nx_stuff && nx_bits[0]) ? ones_q + 3'h1 : 3'h0;
      end
    end
  end

  // register writes
  logic wr_dat;
  assign wr_dat = reg_wr && reg_addr == `SCF_A_DAT;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fmt_q <= `SCF_REG_RST;
      ctl_q <= `SCF_REG_RST;
      sy1_q <= `SCF_REG_RST;
      sy2_q <= `SCF_REG_RST;
      buf_q <= `SCF_REG_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SCF_A_FMT: fmt_q <= reg_wdata;
        `SCF_A_CTL: ctl_q <= reg_wdata;
        `SCF_A_SY1: sy1_q <= reg_wdata;
        `SCF_A_SY2: sy2_q <= reg_wdata;
        `SCF_A_DAT: buf_q <= reg_wdata;
        default:    ;
      endcase
    end
  end

  // buffer flag: a write in the load cycle keeps it full
  always_ff @(posedge core_clk)
  begin
    if (rst)
      buf_full_q <= 1'b0;
    else
      buf_full_q <= wr_dat || (buf_full_q && !(adv && nx_load));
  end

  // idle/crc latch; set wins over the clearing write
  always_ff @(posedge core_clk)
  begin
    if (rst)
      latch_q <= 1'b1;
    else
      latch_q <= (adv && nx_latch) || (latch_q && !(wr_dat && !async_m));
  end

  // all sent when nothing is buffered or on the line
  logic all_sent;
  assign all_sent = !buf_full_q && !stop_q && (st_q == S_OFF || st_q == S_MARK
                    || st_q == S_IDLE || st_q == S_SMARK);

  // modem pins; async rts held low until the line drains
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rts_n_q <= 1'b1;
    else if (!async_m || ctl_q[`SCF_F_RTS])
      rts_n_q <= !ctl_q[`SCF_F_RTS];
    else if (all_sent)
      rts_n_q <= 1'b1;
  end

  // break overrides the serialiser, which keeps running
  always_ff @(posedge core_clk)
  begin
    if (rst)
      txd_q <= 1'b1;
    else
      txd_q <= line_q && !ctl_q[`SCF_F_BRK];
  end

  // status read, data one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_rd && reg_addr == `SCF_A_STA)
    begin
      rdata_q                 <= 8'h00;
      rdata_q[`SCF_S_BUFE]    <= !buf_full_q;
      rdata_q[`SCF_S_ALLSENT] <= all_sent;
      rdata_q[`SCF_S_LATCH]   <= latch_q;
      rdata_q[`SCF_S_SYNCIN]  <= !syn_s2_q;
    end
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata   = rdata_q;
  assign txd         = txd_q;
  assign rts_n       = rts_n_q;
  assign dtr_n       = !ctl_q[`SCF_F_DTR];
  assign sync_o      = 1'b1;
  assign sync_oe     = !(!async_m && fmt_q[`SCF_F_SMODE] == `SCF_M_EXT);
  assign rx_par_en   = fmt_q[`SCF_F_PEN];
  assign rx_par_even = fmt_q[`SCF_F_PEVEN];
  assign rx_crc16    = ctl_q[`SCF_F_POLY];
  assign rx_rate     = fmt_q[`SCF_F_RATE];
  assign rx_addr     = sy1_q;
endmodule // scf_tx

// File: shared/scf_params.svh
// constants for the serial channel format and transmit control block
// assumes an 8-bit register port with a 3-bit address
`ifndef SCF_PARAMS_SVH
`define SCF_PARAMS_SVH
// register addresses
`define SCF_A_FMT 3'h0
`define SCF_A_CTL 3'h1
`define SCF_A_SY1 3'h2
`define SCF_A_SY2 3'h3
`define SCF_A_DAT 3'h4
`define SCF_A_STA 3'h5
// format register fields
`define SCF_F_PEN 0
`define SCF_F_PEVEN 1
`define SCF_F_STOP 3:2
`define SCF_F_SMODE 5:4
`define SCF_F_RATE 7:6
// transmit control fields
`define SCF_F_CRCEN 0
`define SCF_F_RTS 1
`define SCF_F_POLY 2
`define SCF_F_TXEN 3
`define SCF_F_BRK 4
`define SCF_F_LEN 6:5
`define SCF_F_DTR 7
// status fields
`define SCF_S_BUFE 0
`define SCF_S_ALLSENT 1
`define SCF_S_LATCH 2
`define SCF_S_SYNCIN 3
// codes
`define SCF_STOP_SYNC 2'h0
`define SCF_M_BISYNC 2'h1
`define SCF_M_SDLC 2'h2
`define SCF_M_EXT 2'h3
`define SCF_R_X1 2'h0
`define SCF_R_X16 2'h1
`define SCF_R_X32 2'h2
// transmit clock edges per bit for each rate code
`define SCF_DIV1 7'd1
`define SCF_DIV16 7'd16
`define SCF_DIV32 7'd32
`define SCF_DIV64 7'd64
`define SCF_L_PACK 2'h0
`define SCF_L_7 2'h1
`define SCF_L_6 2'h2
// values
`define SCF_REG_RST 8'h00
`define SCF_FLAG 8'h7e
`define SCF_RUN 3'h5
`define SCF_POLY16 16'ha001
`define SCF_POLYCC 16'h8408
`define SCF_PRE16 16'h0000
`define SCF_PRECC 16'hffff
`endif

// File: shared/scf_pkg.sv
// types shared by the serial channel format and transmit control block
// assumes scf_params.svh for all numeric constants
package scf_pkg;
  typedef enum logic [2:0] {S_OFF, S_MARK, S_IDLE, S_DATA, S_CRC, S_SMARK} scf_state_t;
endpackage

// File: shared/scf_crc_if.sv
// carrier between the transmitter and its crc generator
// assumes both ends run on the same core clock
interface scf_crc_if;
  logic        clr;
  logic        step;
  logic        poly16;
  logic [7:0]  dat;
  logic [3:0]  nbits;
  logic [15:0] crc;
  modport mst (output clr, step, poly16, dat, nbits, input crc);
  modport gen (input clr, step, poly16, dat, nbits, output crc);
endinterface

// File: design/scf_crc.sv
// serial crc generator, one whole character per step
// assumes characters arrive lsb first and at most 8 bits wide
`include "scf_params.svh"
module scf_crc
  import scf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // transmitter side
  scf_crc_if.gen   bus
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // fold the valid low bits of the character into the remainder
  always_comb
  begin
    logic fb;
    fb = 1'b0;
    crc_d = crc_q;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < bus.nbits)
      begin
        fb = crc_d[0] ^ bus.dat[i];
        crc_d = (crc_d >> 1) ^ (fb ? (bus.poly16 ? `SCF_POLY16 : `SCF_POLYCC) : 16'h0000);
      end
    end
  end

  // preset differs per polynomial
  always_ff @(posedge core_clk)
  begin
    if (rst || bus.clr)
      crc_q <= bus.poly16 ? `SCF_PRE16 : `SCF_PRECC;
    else if (bus.step)
      crc_q <= crc_d;
  end

  assign bus.crc = crc_q;
endmodule // scf_crc

// File: verification/scf_tx_chk.sv
// checker for the format and transmit control block
// assumes it is bound to scf_tx and sees only its ports
`include "scf_params.svh"
module scf_tx_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and receiver copies
  input wire logic       txd,
  input wire logic       rts_n,
  input wire logic       dtr_n,
  input wire logic       sync_oe,
  input wire logic       rx_par_en,
  input wire logic       rx_par_even,
  input wire logic       rx_crc16,
  input wire logic [1:0] rx_rate,
  input wire logic [7:0] rx_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic wf;
  logic wc;
  // decoded writes to the format and control registers
  assign wf = reg_wr && reg_addr == `SCF_A_FMT;
  assign wc = reg_wr && reg_addr == `SCF_A_CTL;
  property p_par; wf |=> rx_par_en == $past(reg_wdata[`SCF_F_PEN]); endproperty
  a_par: assert property (p_par) else $error("parity enable copy wrong");
  property p_even; wf |=> rx_par_even == $past(reg_wdata[`SCF_F_PEVEN]); endproperty
  a_even: assert property (p_even) else $error("parity sense copy wrong");
  property p_rate; wf |=> rx_rate == $past(reg_wdata[`SCF_F_RATE]); endproperty
  a_rate: assert property (p_rate) else $error("clock rate copy wrong");
  property p_poly; wc |=> rx_crc16 == $past(reg_wdata[`SCF_F_POLY]); endproperty
  a_poly: assert property (p_poly) else $error("polynomial copy wrong");
  property p_sy1;
    reg_wr && reg_addr == `SCF_A_SY1 |=> rx_addr == $past(reg_wdata);
  endproperty
  a_sy1: assert property (p_sy1) else $error("first sync byte wrong");
  property p_soe;
    wf |=> sync_oe == ($past(reg_wdata[`SCF_F_STOP]) != `SCF_STOP_SYNC
                       || $past(reg_wdata[`SCF_F_SMODE]) != `SCF_M_EXT);
  endproperty
  a_soe: assert property (p_soe) else $error("sync pin direction wrong");
  // txd is registered after the control register, so it drops two edges after the write
  property p_brk; wc && reg_wdata[`SCF_F_BRK] ##1 !wc |=> !txd ##1 !txd; endproperty
  a_brk: assert property (p_brk) else $error("break not forcing line low");
  property p_dtr; wc |=> dtr_n == !$past(reg_wdata[`SCF_F_DTR]); endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready pin wrong");
  property p_rst; $fell(rst) |-> txd && rts_n && dtr_n; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  // read data stand only in the cycle after a read strobe
  property p_rdz; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside read cycle");
endmodule // scf_tx_chk

bind scf_tx scf_tx_chk u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rts_n(rts_n),
  .dtr_n(dtr_n), .sync_oe(sync_oe), .rx_par_en(rx_par_en), .rx_par_even(rx_par_even),
  .rx_crc16(rx_crc16), .rx_rate(rx_rate), .rx_addr(rx_addr)
);

// File: verification/scf_line_model.sv
// far-side station: makes the transmit clock, samples the line
// assumes 1x clocking, so each falling clock edge samples one bit
module scf_line_model (
  // control from the bench
  input  wire logic        run,
  input  wire logic        txd,
  input  wire logic [3:0]  nbits,
  // clock and what was received
  output logic             txc,
  output logic      [15:0] rx_char,
  output logic             rx_stop,
  output int               rx_cnt,
  output logic      [15:0] hist
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh;
  int          pos;
  // clock offset from the core clock so phases are unrelated; 1x only
  initial
  begin
    txc = 1'b1;
    #17;
    forever
    begin
      #400;
      txc = run ? ~txc : 1'b1;
    end
  end
  initial
  begin
    rx_cnt = 0;
    pos = -1;
    hist = 16'hffff;
    sh = 16'h0000;
    rx_char = 16'h0000;
    rx_stop = 1'b0;
  end
  // start bit, data and parity right-justified, one stop bit checked
  always @(negedge txc)
  begin
    hist = {txd, hist[15:1]};
    if (pos < 0)
    begin
      if (txd === 1'b0) pos = 0;
    end
    else if (pos < nbits)
    begin
      sh = {txd, sh[15:1]};
      pos++;
    end
    else
    begin
      rx_char = sh >> (16 - nbits);
      rx_stop = txd;
      rx_cnt++;
      pos = -1;
    end
  end
endmodule // scf_line_model

// File: verification/tb.sv
// bench for the format and transmit control block
// assumes scf_tx, its checker bind and the line model are compiled first
`include "scf_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sync_i = 1'b1;
  logic        run = 1'b0;
  logic [3:0]  nb = 4'h8;
  logic [7:0]  reg_rdata;
  logic        txc_pin, txd, rts_n, dtr_n, sync_o, sync_oe;
  logic        rx_par_en, rx_par_even, rx_crc16;
  logic [1:0]  rx_rate;
  logic [7:0]  rx_addr;
  logic [15:0] rx_char, hist;
  logic        rx_stop;
  int          rx_cnt;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #50 core_clk = ~core_clk;
  scf_tx u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .txc_pin(txc_pin), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .sync_i(sync_i),
    .sync_o(sync_o), .sync_oe(sync_oe), .rx_par_en(rx_par_en),
    .rx_par_even(rx_par_even), .rx_crc16(rx_crc16), .rx_rate(rx_rate),
    .rx_addr(rx_addr));
  scf_line_model u_line (.run(run), .txd(txd), .nbits(nb), .txc(txc_pin),
    .rx_char(rx_char), .rx_stop(rx_stop), .rx_cnt(rx_cnt), .hist(hist));
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // true when the last 16 line bits are some rotation of a 16-bit idle pattern
  function automatic logic rot_match(input logic [15:0] h, input logic [15:0] p);
    logic [31:0] pp;
    rot_match = 1'b0;
    pp = {p, p};
    for (int s = 0; s < 16; s++)
      if (pp[s+:16] === h)
        rot_match = 1'b1;
  endfunction
  // bus tasks start just after a rising edge; one idle cycle follows
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic hang;
    error_cnt++;
    test_done;
  endtask
  // one character through the line model, bounded wait
  task automatic send(input logic [7:0] d, input logic [3:0] n, input logic [15:0] e);
    int old;
    old = rx_cnt;
    nb = n;
    wr(`SCF_A_DAT, d);
    for (int i = 0; rx_cnt == old; i++)
    begin
      if (i == 400) hang;
      @(posedge core_clk);
    end
    chk("char", rx_char, e);
    chk("stop", rx_stop, 16'h1);
  endtask
  task automatic t_reset;
    logic [7:0] v;
    chk("idle pins", {txd, rts_n, dtr_n, sync_oe, sync_o}, 16'h1f);
    rd(`SCF_A_STA, v);
    chk("status", v, 16'h07);
    rd(`SCF_A_FMT, v);
    chk("wo read", v, 16'h00);
    rd(3'h7, v);
    chk("unmapped", v, 16'h00);
  endtask
  // lengths and parity, both senses, one and two stop bits
  task automatic t_async;
    logic [7:0]  fm[4] = '{8'h04, 8'h07, 8'h05, 8'h0f};
    logic [1:0]  ln[4] = '{2'h3, 2'h1, 2'h2, 2'h3};
    int          nn[4] = '{8, 7, 6, 8};
    logic [7:0]  d;
    logic [15:0] e;
    for (int i = 0; i < 4; i++)
    begin
      d = 8'ha6 ^ 8'(i);
      wr(`SCF_A_FMT, fm[i]);
      wr(`SCF_A_CTL, 8'h88 | {1'b0, ln[i], 5'h00});
      e = {8'h00, d} & ((16'h1 << nn[i]) - 16'h1);
      if (fm[i][0]) e[nn[i]] = (^e) ^ ~fm[i][1];
      send(d, 4'(nn[i]) + 4'(fm[i][0]), e);
    end
    chk("dtr on", dtr_n, 16'h0);
  endtask
  // packed lengths: ones above a zero marker give the count
  task automatic t_packed;
    logic [7:0] b;
    logic [7:0] m;
    // no parity and one stop, so the model sees exactly k bits
    wr(`SCF_A_FMT, 8'h04);
    wr(`SCF_A_CTL, 8'h08);
    chk("dtr off", dtr_n, 16'h1);
    for (int k = 1; k <= 5; k++)
    begin
      m = (8'h1 << k) - 8'h1;
      b = ~(8'hff >> (5 - k)) | (8'h15 & m);
      send(b, 4'(k), {8'h00, b & m});
    end
  endtask
  task automatic t_break;
    wr(`SCF_A_CTL, 8'h18);
    @(posedge core_clk); // txd settles one edge after the register
    chk("break low", txd, 16'h0);
    wr(`SCF_A_CTL, 8'h08);
    @(posedge core_clk);
    chk("break off", txd, 16'h1);
  endtask
  // async request-to-send waits for empty; sync follows at once
  task automatic t_rts_sync;
    wr(`SCF_A_CTL, 8'h6a);
    @(posedge core_clk); // rts pin settles one edge after the register
    chk("rts on", rts_n, 16'h0);
    nb = 4'h8;
    wr(`SCF_A_DAT, 8'h3c);
    wr(`SCF_A_CTL, 8'h68);
    chk("rts held", rts_n, 16'h0);
    for (int i = 0; rts_n !== 1'b1; i++)
    begin
      if (i == 400) hang;
      @(posedge core_clk);
    end
    chk("rts after empty", txd, 16'h1);
    wr(`SCF_A_SY1, 8'h96);
    wr(`SCF_A_FMT, 8'h00);
    wr(`SCF_A_CTL, 8'h6a);
    @(posedge core_clk);
    chk("sync rts on", rts_n, 16'h0);
    wr(`SCF_A_CTL, 8'h68);
    @(posedge core_clk);
    chk("sync rts off", rts_n, 16'h1);
    repeat (200) @(posedge core_clk);
    chk("idle sync", rot_match(hist, 16'h9696), 16'h1);
    // waits cover the unit in flight at each format change
    wr(`SCF_A_SY2, 8'h3c);
    wr(`SCF_A_FMT, 8'h10);
    repeat (240) @(posedge core_clk);
    chk("bisync idle", rot_match(hist, 16'h3c96), 16'h1);
    wr(`SCF_A_SY2, `SCF_FLAG);
    wr(`SCF_A_FMT, 8'h20); // ccitt still selected
    repeat (320) @(posedge core_clk);
    chk("flag idle", rot_match(hist, {`SCF_FLAG, `SCF_FLAG}), 16'h1);
    wr(`SCF_A_CTL, 8'h60); // disabled in idle, never mid-frame
    repeat (240) @(posedge core_clk);
    chk("idle stop", hist, 16'hffff);
  endtask
  task automatic t_ext;
    logic [7:0] v;
    wr(`SCF_A_FMT, 8'h30);
    chk("ext sync oe", sync_oe, 16'h0);
    sync_i <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(`SCF_A_STA, v);
    chk("sync in", v[3], 16'h1);
    sync_i <= 1'b1;
    wr(`SCF_A_FMT, 8'h44);
    chk("async sync oe", sync_oe, 16'h1);
    chk("rate copy", rx_rate, 16'h1);
    wr(`SCF_A_CTL, 8'h64);
    chk("poly copy", rx_crc16, 16'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    run = 1'b1;
    @(posedge core_clk);
    t_reset;
    t_async;
    t_packed;
    t_break;
    t_rts_sync;
    t_ext;
    test_done;
  end
endmodule // tb
